/* logic/ocr_relay_ctrl.sv */
/*
  Overload relay control of a soft starter: run/stop, remote trip and
  the overload relay function with manual or automatic restart.
  Assumes the bus cycle and breaker data arrive on core_clk; the
  selector pin is asynchronous.
*/
`timescale 1ns/10ps
`include "ocr_map.svh"

module ocr_relay_ctrl
  import ocr_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int REFRESH_CYCLES = `OCR_REFRESH_US * `OCR_CLK_MHZ,
  parameter int RESPONSE_CYCLES = `OCR_RESPONSE_US * `OCR_CLK_MHZ,
  parameter bit EXT_FAULT_STOP = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Host bus cycle
  input wire logic bus_valid,
  input wire logic [7:0] bus_ctrl,
  input wire logic [3:0] bus_profile,
  // Manual/automatic selector pin
  input wire logic sel_auto_pin,
  // Breaker trip block
  input wire ocr_brk_type brk,
  output logic breaker_relay_enable,
  output logic breaker_trip_req,
  // Starter power section
  input wire logic starter_running,
  output logic starter_run,
  output logic external_fault,
  // Status byte 1 to the host
  output ocr_status_type status_byte1
);

  // Thermal threshold compare, one byte 0 to 255 %
  function automatic logic th_ge(input logic [7:0] th, input logic [7:0] lvl);
    th_ge = (th >= lvl);
  endfunction

  // Captured control byte and edges
  ocr_ctrl_type cur;
  ocr_ctrl_type rise;
  ocr_ctrl_type fall;
  // Selector synchroniser
  logic sel_meta_r;
  logic sel_auto_r;
  // Refresh and response counters
  logic [CNT_W-1:0] refresh_cnt_r;
  logic [CNT_W-1:0] resp_cnt_r;
  // Function state
  logic relay_active_r;
  logic remote_trip_r;
  logic ack_req_r;
  logic ol_hot_r; // Relay active and image at 110 % last cycle
  logic starter_run_r;
  logic brk_trip_r;
  ocr_trip_type reason_r;
  ocr_ol_type ol_state_r;
  ocr_ol_type ol_state_nxt;
  // Decoded conditions
  logic profile_ok;
  logic refresh_ok;
  logic relay_req;
  logic at_trip;
  logic below_clear;
  logic manual;
  logic ol_set;
  logic ack_set;
  logic ack_clr;
  logic ext_stop;
  logic run_nxt;

  // Control byte capture and edge detection
  ocr_ctrl_capture u_capture (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus_valid(bus_valid),
    .bus_ctrl(bus_ctrl),
    .cur_r(cur),
    .rise_r(rise),
    .fall_r(fall)
  );

  // Selector pin through two flops
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sel_meta_r <= 1'b0;
      sel_auto_r <= 1'b0;
    end else begin
      sel_meta_r <= sel_auto_pin;
      sel_auto_r <= sel_meta_r;
    end
  end

  // Conditions
  assign profile_ok = (bus_profile >= `OCR_PROFILE_MIN) && (bus_profile <= `OCR_PROFILE_MAX);
  assign refresh_ok = (refresh_cnt_r < CNT_W'(REFRESH_CYCLES));
  assign at_trip = th_ge(brk.thermal_image, `OCR_TH_TRIP);
  assign below_clear = !th_ge(brk.thermal_image, `OCR_TH_CLEAR);
  assign manual = !cur.mode_auto;
  // Relay request needs profile, fresh enable, automatic selector and link
  assign relay_req = cur.relay_en && profile_ok && refresh_ok && sel_auto_r && brk.link_ok;
  // Trip at 110 %, also with unbalance, or on breaker request in manual
  assign ol_set = relay_active_r && (at_trip || (manual && brk.off_request));
  // Set on the onset of heat only, so a mode toggle clears it even while hot
  assign ack_set = relay_active_r && profile_ok && manual && at_trip && !ol_hot_r;
  assign ack_clr = fall.run || rise.mode_auto || cur.mode_auto;
  assign ext_stop = remote_trip_r && EXT_FAULT_STOP;

  // Refresh window: restarted by each bus cycle carrying the enable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      refresh_cnt_r <= CNT_W'(REFRESH_CYCLES);
    end else if (bus_valid) begin
      refresh_cnt_r <= bus_ctrl[`OCR_BIT_RELAY] ? '0 : CNT_W'(REFRESH_CYCLES);
    end else if (refresh_ok) begin
      refresh_cnt_r <= refresh_cnt_r + CNT_W'(1);
    end
  end

  // Relay function activity; off after reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      relay_active_r <= 1'b0;
    end else if (!brk.link_ok) begin
      relay_active_r <= 1'b0;
    end else if (relay_req) begin
      relay_active_r <= 1'b1;
    end else if (below_clear) begin
      relay_active_r <= 1'b0;
    end
  end

  // Overload trip state next value
  always_comb begin
    ol_state_nxt = ol_state_r;
    case (ol_state_r)
      OCR_OL_IDLE: begin
        if (ol_set) begin
          ol_state_nxt = OCR_OL_TRIPPED;
        end
      end
      OCR_OL_TRIPPED: begin
        // Released only by the image, not by the enable
        if (below_clear) begin
          ol_state_nxt = OCR_OL_IDLE;
        end
      end
      default: begin
        ol_state_nxt = OCR_OL_IDLE;
      end
    endcase
  end

  // Overload trip state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ol_state_r <= OCR_OL_IDLE;
    end else begin
      ol_state_r <= ol_state_nxt;
    end
  end

  // Remote trip latch; a new edge wins over acknowledge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      remote_trip_r <= 1'b0;
    end else if (rise.remote_trip && profile_ok) begin
      remote_trip_r <= 1'b1;
    end else if (fall.run) begin
      remote_trip_r <= 1'b0;
    end
  end

  // Heat seen last cycle, for the onset of an overload
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ol_hot_r <= 1'b0;
    end else begin
      ol_hot_r <= relay_active_r && at_trip;
    end
  end

  // Acknowledge flag; set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack_req_r <= 1'b0;
    end else if (ack_set) begin
      ack_req_r <= 1'b1;
    end else if (ack_clr) begin
      ack_req_r <= 1'b0;
    end
  end

  // Run decision: start only below 100 % with flag clear
  always_comb begin
    run_nxt = cur.run && !ack_req_r && !ack_set && !ext_stop;
    run_nxt = run_nxt && (ol_state_r == OCR_OL_IDLE) && !ol_set;
    run_nxt = run_nxt && (starter_run_r || below_clear);
  end

  // Run command register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      starter_run_r <= 1'b0;
    end else begin
      starter_run_r <= run_nxt;
    end
  end

  // Backup: breaker trips if the starter keeps running after remote trip
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resp_cnt_r <= '0;
      brk_trip_r <= 1'b0;
    end else if (!remote_trip_r) begin
      resp_cnt_r <= '0;
      brk_trip_r <= 1'b0;
    end else if (starter_running && !brk_trip_r) begin
      resp_cnt_r <= resp_cnt_r + CNT_W'(1);
      brk_trip_r <= (resp_cnt_r == CNT_W'(RESPONSE_CYCLES - 1));
    end
  end

  // Trip indication: relay overload first, then remote trip
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reason_r <= OCR_TRIP_NONE;
    end else if ((ol_state_r == OCR_OL_TRIPPED) || (relay_active_r && at_trip)) begin
      reason_r <= OCR_TRIP_RELAY;
    end else if (remote_trip_r) begin
      reason_r <= OCR_TRIP_REMOTE;
    end else begin
      reason_r <= OCR_TRIP_NONE;
    end
  end

  // Outputs
  assign starter_run = starter_run_r;
  assign external_fault = remote_trip_r;
  assign breaker_relay_enable = relay_active_r;
  assign breaker_trip_req = brk_trip_r;
  assign status_byte1 = '{ack_req: ack_req_r, reason: reason_r, spare: 4'h0};

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Named steps
  sequence s_remote_edge;
    rise.remote_trip && profile_ok;
  endsequence
  sequence s_ol_hot;
    relay_active_r && at_trip;
  endsequence
  sequence s_auto_ready;
    (ol_state_r == OCR_OL_IDLE) && cur.run && cur.mode_auto && !ack_req_r && below_clear
      && !remote_trip_r && !starter_run_r && !ol_set;
  endsequence

  AST_RUN_FALL_ACK: assert property ((fall.run && !ack_set) |=> !ack_req_r)
    else $error("run fall did not clear acknowledge");
  AST_REMOTE_REPORT: assert property (s_remote_edge |=> remote_trip_r ##1 reason_r != OCR_TRIP_NONE)
    else $error("remote trip not reported");
  AST_REMOTE_STOP: assert property (ext_stop |=> !starter_run_r)
    else $error("starter kept running after remote trip");
  AST_PROFILE_GATE: assert property ((!profile_ok && !remote_trip_r && !relay_active_r)
    |=> !remote_trip_r)
    else $error("remote trip taken outside profiles");
  AST_OVERLOAD_STOP: assert property (s_ol_hot |=> !starter_run_r ##0 ol_state_r == OCR_OL_TRIPPED)
    else $error("overload did not stop starter");
  AST_SEL_GATE: assert property ((!sel_auto_r && !relay_active_r) |=> !relay_active_r)
    else $error("relay active with manual selector");
  AST_REFRESH: assert property ((!refresh_ok && !relay_active_r) |=> !relay_active_r)
    else $error("relay active without refresh");
  AST_LINK_LOSS: assert property (!brk.link_ok |=> !relay_active_r)
    else $error("relay active after link loss");
  AST_TRIP_HOLD: assert property ((ol_state_r == OCR_OL_TRIPPED && !below_clear)
    |=> ol_state_r == OCR_OL_TRIPPED ##0 !starter_run_r)
    else $error("trip released above 100 percent");
  AST_ACK_SET: assert property (ack_set |=> ack_req_r)
    else $error("acknowledge flag not set");
  AST_CODE_FIVE: assert property (s_ol_hot |=> ##1 reason_r == OCR_TRIP_RELAY)
    else $error("code five missing during overload");
  AST_MODE_CLEAR: assert property (rise.mode_auto |=> !ack_req_r)
    else $error("mode change did not clear acknowledge");
  AST_START_GATE: assert property ((!starter_run_r && (ack_req_r || !below_clear))
    |=> !starter_run_r)
    else $error("starter switched on while blocked");
  AST_DEACT_WAIT: assert property ((relay_active_r && !below_clear && brk.link_ok)
    |=> relay_active_r)
    else $error("relay deactivated above 100 percent");
  AST_OFF_REQUEST: assert property ((relay_active_r && manual && brk.off_request)
    |=> !starter_run_r)
    else $error("breaker off request ignored");
  AST_AUTO_RESTART: assert property (s_auto_ready |=> starter_run_r)
    else $error("automatic restart missing");
  AST_AUTO_NO_ACK: assert property ((cur.mode_auto && !ack_req_r) |=> !ack_req_r)
    else $error("acknowledge raised in automatic mode");
  AST_CODE_CLEAR: assert property ((ol_state_r == OCR_OL_TRIPPED && below_clear)
    |=> ol_state_r == OCR_OL_IDLE)
    else $error("relay trip code not cleared");
  AST_BACKUP_TRIP: assert property ((remote_trip_r && starter_running && !brk_trip_r
    && resp_cnt_r == CNT_W'(RESPONSE_CYCLES - 1)) |=> brk_trip_r)
    else $error("breaker backup trip missing");

endmodule

/* logic/ocr_map.svh */
/*
  Constants of the overload relay control block: control byte field
  positions, reset values, thermal thresholds, trip reason codes, timing.
  Assumes inclusion by the package and the design files, guarded here.
*/
`ifndef OCR_MAP_SVH
`define OCR_MAP_SVH

// Control byte offset and reset value
`define OCR_CTRL_OFS 8'h00
`define OCR_CTRL_RST 8'h00

// Control byte bit positions
`define OCR_BIT_RUN 0
`define OCR_BIT_RTRIP 1
`define OCR_BIT_RELAY 2
`define OCR_BIT_MODE 3

// Status byte 1 field positions
`define OCR_ST_REASON_LSB 4
`define OCR_ST_ACK 7

// Profiles that carry the breaker control bits
`define OCR_PROFILE_MIN 4'h1
`define OCR_PROFILE_MAX 4'h9

// Thermal image thresholds (110 % and 100 %)
`define OCR_TH_TRIP 8'h6e
`define OCR_TH_CLEAR 8'h64

// Trip reason codes
`define OCR_CODE_NONE 3'h0
`define OCR_CODE_RELAY 3'h5
`define OCR_CODE_REMOTE 3'h6

// Timing: clock rate, refresh window, starter response window
`define OCR_CLK_MHZ 100
`define OCR_REFRESH_US 10000
`define OCR_RESPONSE_US 100000

`endif

/* logic/ocr_pkg.sv */
/*
  Types of the overload relay control block: control byte layout,
  status byte 1 layout, breaker inputs, trip codes and states.
  Assumes ocr_map.svh is on the include path.
*/
`include "ocr_map.svh"

package ocr_pkg;

  // Host control byte as received per bus cycle
  typedef struct packed {
    logic [3:0] spare;
    logic mode_auto;
    logic relay_en;
    logic remote_trip;
    logic run;
  } ocr_ctrl_type;

  // Trip indication codes
  typedef enum logic [2:0] {
    OCR_TRIP_NONE = `OCR_CODE_NONE,
    OCR_TRIP_RELAY = `OCR_CODE_RELAY,
    OCR_TRIP_REMOTE = `OCR_CODE_REMOTE
  } ocr_trip_type;

  // Status byte 1 as reported to the host
  typedef struct packed {
    logic ack_req;
    ocr_trip_type reason;
    logic [3:0] spare;
  } ocr_status_type;

  // Data from the breaker trip block
  typedef struct packed {
    logic [7:0] thermal_image;
    logic unbalance;
    logic off_request;
    logic link_ok;
  } ocr_brk_type;

  // Overload trip state
  typedef enum logic [0:0] {
    OCR_OL_IDLE = 1'b0,
    OCR_OL_TRIPPED = 1'b1
  } ocr_ol_type;

endpackage

/* logic/ocr_ctrl_capture.sv */
/*
  Holds the latest host control byte and flags per-bit edges against
  the byte of the previous bus cycle. Assumes bus_valid and bus_ctrl are
  on core_clk.
*/
`timescale 1ns/10ps

`include "ocr_map.svh"

module ocr_ctrl_capture
  import ocr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus cycle
  input wire logic bus_valid,
  input wire logic [7:0] bus_ctrl,
  // Captured byte and edge pulses
  output ocr_ctrl_type cur_r,
  output ocr_ctrl_type rise_r,
  output ocr_ctrl_type fall_r
);

  // Latch byte and compare with the previous bus cycle's byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cur_r <= ocr_ctrl_type'(`OCR_CTRL_RST);
      rise_r <= ocr_ctrl_type'(8'h00);
      fall_r <= ocr_ctrl_type'(8'h00);
    end else if (bus_valid) begin
      cur_r <= ocr_ctrl_type'(bus_ctrl);
      rise_r <= ocr_ctrl_type'(bus_ctrl & ~cur_r);
      fall_r <= ocr_ctrl_type'(~bus_ctrl & cur_r);
    end else begin
      rise_r <= ocr_ctrl_type'(8'h00);
      fall_r <= ocr_ctrl_type'(8'h00);
    end
  end

  // Remote trip edge on every 0 to 1 change
  AST_RTRIP_EDGE: assert property (@(posedge core_clk) disable iff (!rstn)
    (bus_valid && bus_ctrl[`OCR_BIT_RTRIP] && !cur_r.remote_trip) |=> rise_r.remote_trip)
    else $error("remote trip edge missed");

endmodule

/* sim/ocr_brk_model.sv */
/*
  Behavioural breaker trip block and starter power section.
  Assumes the bench sets the targets on core_clk by non-blocking assignment.
*/
`timescale 1ns/10ps

module ocr_brk_model
  import ocr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Targets from the bench
  input wire logic [7:0] img_set,
  input wire logic link_set,
  input wire logic unb_set,
  input wire logic off_set,
  input wire logic stuck,
  // Starter power section
  input wire logic starter_run,
  output logic starter_running,
  // Breaker data to the block
  output ocr_brk_type brk
);
  // Known values from time zero
  initial begin
    brk = '0;
    starter_running = 1'b0;
  end

  // Breaker data refreshed every cycle
  always @(posedge core_clk) begin
    brk.link_ok <= link_set;
    brk.unbalance <= unb_set;
    brk.off_request <= off_set;
    if (link_set) begin
      // One byte, 0 to 255 %
      brk.thermal_image <= img_set;
    end else begin
      // Dead link: stale byte is not trusted, shown toggling
      brk.thermal_image <= ~brk.thermal_image;
    end
  end

  // Power section follows its command unless told to hang on
  always @(posedge core_clk) begin
    if (!stuck || !starter_running) begin
      starter_running <= starter_run;
    end
  end
endmodule

/* sim/tb_top.sv */
/*
  Self-checking bench of the overload relay control: cyclic host,
  breaker model, directed and random scenarios.
  Assumes the package is compiled first and ocr_brk_model is present.
*/
`timescale 1ns/10ps

module tb_top
  import ocr_pkg::*;
;
  // Clock, reset, host bus
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_valid = 1'b0;
  logic [7:0] bus_ctrl = 8'h00;
  logic [3:0] bus_profile = 4'h1;
  logic sel_auto_pin = 1'b1;
  // Breaker model targets
  logic [7:0] img = 8'h10;
  logic link = 1'b1;
  logic unb = 1'b0;
  logic off = 1'b0;
  logic stuck = 1'b0;
  // Host state and counters
  logic [7:0] host_ctrl = 8'h00;
  logic cyc_on = 1'b1;
  logic [1:0] cyc_cnt = 2'h0;
  int seed = 32'h68ff5bfe;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  // Block outputs and breaker data
  ocr_brk_type brk;
  logic starter_running;
  logic breaker_relay_enable;
  logic breaker_trip_req;
  logic starter_run;
  logic external_fault;
  ocr_status_type status_byte1;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Cyclic host resends the byte every fourth cycle
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 2'h1;
    bus_valid <= cyc_on && rstn && (cyc_cnt == 2'h3);
    bus_ctrl <= host_ctrl;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end

  ocr_relay_ctrl #(.REFRESH_CYCLES(20), .RESPONSE_CYCLES(30)) dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus_valid(bus_valid),
    .bus_ctrl(bus_ctrl),
    .bus_profile(bus_profile),
    .sel_auto_pin(sel_auto_pin),
    .brk(brk),
    .breaker_relay_enable(breaker_relay_enable),
    .breaker_trip_req(breaker_trip_req),
    .starter_running(starter_running),
    .starter_run(starter_run),
    .external_fault(external_fault),
    .status_byte1(status_byte1)
  );

  ocr_brk_model brk_model (
    .core_clk(core_clk),
    .img_set(img),
    .link_set(link),
    .unb_set(unb),
    .off_set(off),
    .stuck(stuck),
    .starter_run(starter_run),
    .starter_running(starter_running),
    .brk(brk)
  );

  // Verdict and end of run
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Flag widened to a byte
  function automatic logic [7:0] b8(input logic v);
    return {7'h0, v};
  endfunction

  // Expected status byte
  function automatic logic [7:0] stat(input logic ack, input logic [2:0] code);
    return {ack, code, 4'h0};
  endfunction

  // Wait n clock cycles, then sample off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // New byte for the cyclic host
  task automatic put(input logic [7:0] v);
    @(posedge core_clk);
    host_ctrl <= v;
    settle(12);
  endtask

  // New thermal image at the breaker
  task automatic heat(input logic [7:0] v);
    @(posedge core_clk);
    img <= v;
    settle(12);
  endtask

  // Run, fault and status together
  task automatic outs(input logic run, input logic ext, input logic [7:0] st);
    chk(b8(starter_run), b8(run));
    chk(b8(external_fault), b8(ext));
    chk(status_byte1, st);
  endtask

  initial begin
    // Reset for 16 cycles
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    settle(4);
    outs(1'b0, 1'b0, 8'h00);
    chk(b8(breaker_relay_enable), 8'h00);
    put(8'h01);
    outs(1'b1, 1'b0, 8'h00);
    // Profile above 9 ignores trip and relay bits
    @(posedge core_clk);
    bus_profile <= 4'($unsigned($random(seed)) % 6 + 10);
    put(8'h03);
    outs(1'b1, 1'b0, 8'h00);
    put(8'h07);
    chk(b8(breaker_relay_enable), 8'h00);
    put(8'h01);
    // Remote trip edge in a breaker profile
    @(posedge core_clk);
    bus_profile <= 4'($unsigned($random(seed)) % 9 + 1);
    put(8'h03);
    outs(1'b0, 1'b1, stat(1'b0, OCR_TRIP_REMOTE));
    chk(b8(breaker_trip_req), 8'h00);
    put(8'h02);
    outs(1'b0, 1'b0, 8'h00);
    put(8'h03);
    outs(1'b1, 1'b0, 8'h00);
    // Starter ignores the fault: breaker backs up
    put(8'h01);
    @(posedge core_clk);
    stuck <= 1'b1;
    put(8'h03);
    settle(40);
    chk(b8(breaker_trip_req), 8'h01);
    @(posedge core_clk);
    stuck <= 1'b0;
    put(8'h02);
    chk(b8(breaker_trip_req), 8'h00);
    // Manual relay trip, hold, acknowledge
    put(8'h05);
    chk(b8(breaker_relay_enable), 8'h01);
    heat(8'($unsigned($random(seed)) % 10 + 100));
    outs(1'b1, 1'b0, 8'h00);
    heat(8'h6e);
    outs(1'b0, 1'b0, stat(1'b1, OCR_TRIP_RELAY));
    heat(8'h64);
    outs(1'b0, 1'b0, stat(1'b1, OCR_TRIP_RELAY));
    heat(8'h63);
    outs(1'b0, 1'b0, stat(1'b1, OCR_TRIP_NONE));
    put(8'h04);
    chk(status_byte1, 8'h00);
    put(8'h05);
    outs(1'b1, 1'b0, 8'h00);
    // Mode toggle clears the flag while still hot
    heat(8'h70);
    put(8'h0d);
    chk(status_byte1, stat(1'b0, OCR_TRIP_RELAY));
    put(8'h05);
    chk(status_byte1, stat(1'b0, OCR_TRIP_RELAY));
    heat(8'h63);
    // Automatic mode
    put(8'h0d);
    chk(b8(starter_run), 8'h01);
    heat(8'h6e);
    outs(1'b0, 1'b0, stat(1'b0, OCR_TRIP_RELAY));
    heat(8'h63);
    outs(1'b1, 1'b0, 8'h00);
    // Breaker asks for a stop in manual mode
    put(8'h05);
    @(posedge core_clk);
    off <= 1'b1;
    settle(12);
    chk(b8(starter_run), 8'h00);
    @(posedge core_clk);
    off <= 1'b0;
    put(8'h04);
    put(8'h05);
    // Unbalance: no stop at 101 %, stop at 110 %
    @(posedge core_clk);
    unb <= 1'b1;
    heat(8'h65);
    chk(b8(starter_run), 8'h01);
    heat(8'h6e);
    chk(b8(starter_run), 8'h00);
    heat(8'h63);
    unb <= 1'b0;
    put(8'h04);
    // Relay dropped in mid-trip
    put(8'h05);
    heat(8'h70);
    put(8'h01);
    chk(b8(breaker_relay_enable), 8'h01);
    outs(1'b0, 1'b0, stat(1'b1, OCR_TRIP_RELAY));
    heat(8'h63);
    chk(b8(breaker_relay_enable), 8'h00);
    outs(1'b0, 1'b0, stat(1'b1, OCR_TRIP_NONE));
    // Selector, refresh lapse, link loss
    put(8'h00);
    put(8'h05);
    @(posedge core_clk);
    sel_auto_pin <= 1'b0;
    settle(12);
    chk(b8(breaker_relay_enable), 8'h00);
    @(posedge core_clk);
    sel_auto_pin <= 1'b1;
    settle(12);
    chk(b8(breaker_relay_enable), 8'h01);
    @(posedge core_clk);
    cyc_on <= 1'b0;
    settle(40);
    chk(b8(breaker_relay_enable), 8'h00);
    @(posedge core_clk);
    cyc_on <= 1'b1;
    settle(12);
    chk(b8(breaker_relay_enable), 8'h01);
    @(posedge core_clk);
    link <= 1'b0;
    settle(3);
    chk(b8(breaker_relay_enable), 8'h00);
    close_out();
  end
endmodule
